// *** rtl/lfc_pkg.sv ***
// lfc_pkg: register map, field layout, reset values and linefeed state codes
// for the linefeed state and dc feed control block.
// assumes: byte-wide registers reached over the serial control port.
package lfc_pkg;

   // ------------------------------------------------------------------
   // register addresses (7-bit direct register space)
   // ------------------------------------------------------------------
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam logic [6:0] ADDR_LINEFEED_STATE = 7'h40;
   localparam logic [6:0] ADDR_ALARM_CTRL = 7'h44;
   localparam logic [6:0] ADDR_ALARM_STATUS = 7'h45;
   localparam logic [6:0] ADDR_POWER_MONITOR = 7'h4D;
   localparam logic [6:0] ADDR_LOOP_VOLTAGE = 7'h4E;
   localparam logic [6:0] ADDR_LOOP_CURRENT = 7'h4F;
   localparam logic [6:0] ADDR_LOOP_CURRENT_LIMIT = 7'h47;
   localparam logic [6:0] ADDR_OPEN_CIRCUIT_VOLTAGE = 7'h48;
   localparam logic [6:0] ADDR_COMMON_MODE_VOLTAGE = 7'h49;

   // ------------------------------------------------------------------
   // field widths and reset values
   // ------------------------------------------------------------------
   localparam int LOOP_CURRENT_LIMIT_CODE_W = 3;
   localparam int VOC_W = 6;
   localparam int VCM_W = 6;
   localparam int LF_W = 3;
   // 20 mA -> code 0
   localparam logic [2:0] LOOP_CURRENT_LIMIT_CODE_RESET = 3'h0;
   // 48 V / 1.5 V -> code 32
   localparam logic [5:0] VOC_RESET = 6'h20;
   // 3 V / 1.5 V -> code 2
   localparam logic [5:0] VCM_RESET = 6'h02;
   localparam int BIT_AUTO_OPEN = 0;
   localparam int BIT_ALARM_IRQ_EN = 1;
   localparam int BIT_ALARM_FLAG = 0;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // ------------------------------------------------------------------
   // serial frame: command byte (read flag + address), then data byte
   // ------------------------------------------------------------------
   localparam int FRAME_BITS = 16;
   localparam int CMD_BITS = 8;
   localparam int CMD_READ_BIT = 7;

   typedef enum logic [2:0] {
      LF_OPEN = 3'b000,
      LF_FWD_ACTIVE = 3'b001,
      LF_FWD_OHT = 3'b010,
      LF_TIP_OPEN = 3'b011,
      LF_RINGING = 3'b100,
      LF_REV_ACTIVE = 3'b101,
      LF_REV_OHT = 3'b110,
      LF_RING_OPEN = 3'b111
   } lfc_state_e;

   typedef enum logic [1:0] {
      SP_IDLE = 2'b00,
      SP_CMD = 2'b01,
      SP_DATA = 2'b10
   } lfc_spi_phase_e;

endpackage

// *** rtl/lfc_drive_if.sv ***
// lfc_drive_if: carries the linefeed state to the decoder and the decoded
// driver and audio enables back to the top.
// assumes: one clock domain; decoder is purely combinational.
`timescale 1ns/100ps
interface lfc_drive_if;
   lfc_pkg::lfc_state_e state;
   logic tip_drive_en;
   logic ring_drive_en;
   logic audio_path_en;
   logic ringing_gen_en;
   logic reverse_polarity;

   modport ctrl (
      output state,
      input tip_drive_en,
      input ring_drive_en,
      input audio_path_en,
      input ringing_gen_en,
      input reverse_polarity
   );

   modport dec (
      input state,
      output tip_drive_en,
      output ring_drive_en,
      output audio_path_en,
      output ringing_gen_en,
      output reverse_polarity
   );
endinterface

// *** rtl/lfc_state_decode.sv ***
// lfc_state_decode: maps the linefeed state onto tip/ring driver enables,
// audio path enable, ringing generator enable and polarity.
// assumes: the caller registers the results before they leave the chip.
`timescale 1ns/100ps
module lfc_state_decode (
   lfc_drive_if.dec drv
);

   always_comb begin
      drv.tip_drive_en = 1'b0;
      drv.ring_drive_en = 1'b0;
      drv.audio_path_en = 1'b0;
      drv.ringing_gen_en = 1'b0;
      drv.reverse_polarity = 1'b0;
      case (drv.state)
         lfc_pkg::LF_OPEN: begin
            drv.tip_drive_en = 1'b0;
            drv.ring_drive_en = 1'b0;
         end
         lfc_pkg::LF_FWD_ACTIVE: begin
            drv.tip_drive_en = 1'b1;
            drv.ring_drive_en = 1'b1;
         end
         lfc_pkg::LF_FWD_OHT: begin
            drv.tip_drive_en = 1'b1;
            drv.ring_drive_en = 1'b1;
            drv.audio_path_en = 1'b1;
         end
         lfc_pkg::LF_TIP_OPEN: begin
            drv.ring_drive_en = 1'b1;
         end
         lfc_pkg::LF_RINGING: begin
            drv.tip_drive_en = 1'b1;
            drv.ring_drive_en = 1'b1;
            drv.ringing_gen_en = 1'b1;
         end
         lfc_pkg::LF_REV_ACTIVE: begin
            drv.tip_drive_en = 1'b1;
            drv.ring_drive_en = 1'b1;
            drv.reverse_polarity = 1'b1;
         end
         lfc_pkg::LF_REV_OHT: begin
            drv.tip_drive_en = 1'b1;
            drv.ring_drive_en = 1'b1;
            drv.audio_path_en = 1'b1;
            drv.reverse_polarity = 1'b1;
         end
         lfc_pkg::LF_RING_OPEN: begin
            drv.tip_drive_en = 1'b1;
         end
         default: begin
            drv.tip_drive_en = 1'b0;
         end
      endcase
   end

endmodule

// *** rtl/lfc_top.sv ***
// lfc_top: linefeed state and dc feed control register bank behind a
// serial control port, with state decode and auto-open on power alarm.
// assumes: serial clock at most clk/8; measurement and alarm inputs are
// produced on clk by the converter and power monitor logic.
`timescale 1ns/100ps
module lfc_top (
   input wire logic clk,
   input wire logic nrst,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_sdi,
   output logic spi_sdo_out,
   output logic spi_sdo_oe,
   input wire logic meas_valid,
   input wire logic [7:0] meas_loop_voltage,
   input wire logic [7:0] meas_loop_current,
   input wire logic [7:0] meas_power,
   input wire logic power_alarm_event,
   output logic [2:0] loop_current_limit_code,
   output logic [5:0] open_circuit_voltage_code,
   output logic [5:0] common_mode_offset_code,
   output logic [2:0] linefeed_state_field,
   output logic tip_drive_en,
   output logic ring_drive_en,
   output logic audio_path_en,
   output logic ringing_gen_en,
   output logic reverse_polarity,
   output logic power_alarm_irq
);

   // ------------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------------
   logic sclk_s1;
   logic sclk_s2;
   logic sclk_s3;
   logic cs_n_s1;
   logic cs_n_s2;
   logic sdi_s1;
   logic sdi_s2;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sclk_s1 <= 1'b1;
         sclk_s2 <= 1'b1;
         sclk_s3 <= 1'b1;
         cs_n_s1 <= 1'b1;
         cs_n_s2 <= 1'b1;
         sdi_s1 <= 1'b0;
         sdi_s2 <= 1'b0;
      end else begin
         sclk_s1 <= spi_sclk;
         sclk_s2 <= sclk_s1;
         sclk_s3 <= sclk_s2;
         cs_n_s1 <= spi_cs_n;
         cs_n_s2 <= cs_n_s1;
         sdi_s1 <= spi_sdi;
         sdi_s2 <= sdi_s1;
      end
   end

   logic sclk_rise;
   logic sclk_fall;
   assign sclk_rise = sclk_s2 & ~sclk_s3;
   assign sclk_fall = ~sclk_s2 & sclk_s3;

   // ------------------------------------------------------------------
   // serial frame engine
   // ------------------------------------------------------------------
   lfc_pkg::lfc_spi_phase_e phase;
   logic [3:0] bit_cnt;
   logic [7:0] shift_in;
   logic cmd_read;
   logic [6:0] cmd_addr;
   logic [7:0] rd_shift;
   logic wr_strobe;
   logic [7:0] wr_data;
   logic [7:0] rd_data;
   logic [7:0] next_shift_in;

   assign next_shift_in = {shift_in[6:0], sdi_s2};

   // frame: 8 command bits then 8 data bits, msb first
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         phase <= lfc_pkg::SP_IDLE;
         bit_cnt <= 4'h0;
         shift_in <= 8'h00;
         cmd_read <= 1'b0;
         cmd_addr <= 7'h00;
      end else if (cs_n_s2) begin
         phase <= lfc_pkg::SP_IDLE;
         bit_cnt <= 4'h0;
      end else begin
         case (phase)
            lfc_pkg::SP_IDLE: begin
               phase <= lfc_pkg::SP_CMD;
               bit_cnt <= 4'h0;
            end
            lfc_pkg::SP_CMD: begin
               if (sclk_rise) begin
                  shift_in <= next_shift_in;
                  bit_cnt <= bit_cnt + 4'h1;
                  if (bit_cnt == 4'(lfc_pkg::CMD_BITS - 1)) begin
                     cmd_read <= next_shift_in[lfc_pkg::CMD_READ_BIT];
                     cmd_addr <= next_shift_in[6:0];
                     phase <= lfc_pkg::SP_DATA;
                  end
               end
            end
            lfc_pkg::SP_DATA: begin
               if (sclk_rise) begin
                  shift_in <= next_shift_in;
                  bit_cnt <= bit_cnt + 4'h1;
                  if (bit_cnt == 4'(lfc_pkg::FRAME_BITS - 1)) begin
                     phase <= lfc_pkg::SP_IDLE;
                  end
               end
            end
            default: begin
               phase <= lfc_pkg::SP_IDLE;
            end
         endcase
      end
   end

   // one-cycle write strobe at the last data bit
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_strobe <= 1'b0;
         wr_data <= 8'h00;
      end else begin
         wr_strobe <= 1'b0;
         if (!cs_n_s2 && phase == lfc_pkg::SP_DATA && sclk_rise &&
             bit_cnt == 4'(lfc_pkg::FRAME_BITS - 1) && !cmd_read) begin
            wr_strobe <= 1'b1;
            wr_data <= next_shift_in;
         end
      end
   end

   // read data shifted out on falling edges after the command byte
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_shift <= 8'h00;
         spi_sdo_out <= 1'b0;
         spi_sdo_oe <= 1'b0;
      end else if (cs_n_s2) begin
         spi_sdo_oe <= 1'b0;
         spi_sdo_out <= 1'b0;
      end else if (phase == lfc_pkg::SP_DATA && cmd_read) begin
         spi_sdo_oe <= 1'b1;
         // latch once cmd_addr holds this frame's address
         if (!spi_sdo_oe) begin
            rd_shift <= rd_data;
         end else if (sclk_fall) begin
            spi_sdo_out <= rd_shift[7];
            rd_shift <= {rd_shift[6:0], 1'b0};
         end
      end else begin
         rd_shift <= rd_data;
         spi_sdo_oe <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // dc feed settings
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         loop_current_limit_code <= lfc_pkg::LOOP_CURRENT_LIMIT_CODE_RESET;
         open_circuit_voltage_code <= lfc_pkg::VOC_RESET;
         common_mode_offset_code <= lfc_pkg::VCM_RESET;
      end else if (wr_strobe) begin
         case (cmd_addr)
            lfc_pkg::ADDR_LOOP_CURRENT_LIMIT: begin
               loop_current_limit_code <= wr_data[lfc_pkg::LOOP_CURRENT_LIMIT_CODE_W-1:0];
            end
            lfc_pkg::ADDR_OPEN_CIRCUIT_VOLTAGE: begin
               open_circuit_voltage_code <= wr_data[lfc_pkg::VOC_W-1:0];
            end
            lfc_pkg::ADDR_COMMON_MODE_VOLTAGE: begin
               common_mode_offset_code <= wr_data[lfc_pkg::VCM_W-1:0];
            end
            default: begin
               loop_current_limit_code <= loop_current_limit_code;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // power alarm control and flag
   // ------------------------------------------------------------------
   logic auto_open_on_power_alarm;
   logic alarm_irq_en;
   logic alarm_flag;
   logic ctrl_wr;
   logic status_wr;
   assign ctrl_wr = wr_strobe && cmd_addr == lfc_pkg::ADDR_ALARM_CTRL;
   assign status_wr = wr_strobe && cmd_addr == lfc_pkg::ADDR_ALARM_STATUS;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         auto_open_on_power_alarm <= 1'b0;
         alarm_irq_en <= 1'b0;
      end else if (ctrl_wr) begin
         auto_open_on_power_alarm <= wr_data[lfc_pkg::BIT_AUTO_OPEN];
         alarm_irq_en <= wr_data[lfc_pkg::BIT_ALARM_IRQ_EN];
      end
   end

   // sticky flag; a new event beats a write-one clear
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         alarm_flag <= 1'b0;
      end else if (power_alarm_event) begin
         alarm_flag <= 1'b1;
      end else if (status_wr && wr_data[lfc_pkg::BIT_ALARM_FLAG]) begin
         alarm_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         power_alarm_irq <= 1'b0;
      end else begin
         power_alarm_irq <= alarm_flag & alarm_irq_en;
      end
   end

   // ------------------------------------------------------------------
   // linefeed state field
   // ------------------------------------------------------------------
   // auto-open wins over a host write in the same cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         linefeed_state_field <= lfc_pkg::LF_OPEN;
      end else if (power_alarm_event && auto_open_on_power_alarm) begin
         linefeed_state_field <= lfc_pkg::LF_OPEN;
      end else if (wr_strobe && cmd_addr == lfc_pkg::ADDR_LINEFEED_STATE) begin
         linefeed_state_field <= wr_data[lfc_pkg::LF_W-1:0];
      end
   end

   // ------------------------------------------------------------------
   // state decode and registered drive outputs
   // ------------------------------------------------------------------
   lfc_drive_if drv ();

   assign drv.state = lfc_pkg::lfc_state_e'(linefeed_state_field);

   lfc_state_decode u_decode (
      .drv(drv)
   );

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tip_drive_en <= 1'b0;
         ring_drive_en <= 1'b0;
         audio_path_en <= 1'b0;
         ringing_gen_en <= 1'b0;
         reverse_polarity <= 1'b0;
      end else begin
         tip_drive_en <= drv.tip_drive_en;
         ring_drive_en <= drv.ring_drive_en;
         audio_path_en <= drv.audio_path_en;
         ringing_gen_en <= drv.ringing_gen_en;
         reverse_polarity <= drv.reverse_polarity;
      end
   end

   // ------------------------------------------------------------------
   // measurement capture
   // ------------------------------------------------------------------
   logic [7:0] loop_voltage_meas;
   logic [7:0] loop_current_meas;
   logic [7:0] power_meas;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         loop_voltage_meas <= 8'h00;
         loop_current_meas <= 8'h00;
         power_meas <= 8'h00;
      end else if (meas_valid) begin
         loop_voltage_meas <= meas_loop_voltage;
         loop_current_meas <= meas_loop_current;
         power_meas <= meas_power;
      end
   end

   // ------------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------------
   always_comb begin
      rd_data = lfc_pkg::READ_UNMAPPED;
      case (cmd_addr)
         lfc_pkg::ADDR_LINEFEED_STATE: begin
            rd_data = {5'h00, linefeed_state_field};
         end
         lfc_pkg::ADDR_ALARM_CTRL: begin
            rd_data = {6'h00, alarm_irq_en, auto_open_on_power_alarm};
         end
         lfc_pkg::ADDR_ALARM_STATUS: begin
            rd_data = {7'h00, alarm_flag};
         end
         lfc_pkg::ADDR_LOOP_CURRENT_LIMIT: begin
            rd_data = {5'h00, loop_current_limit_code};
         end
         lfc_pkg::ADDR_OPEN_CIRCUIT_VOLTAGE: begin
            rd_data = {2'h0, open_circuit_voltage_code};
         end
         lfc_pkg::ADDR_COMMON_MODE_VOLTAGE: begin
            rd_data = {2'h0, common_mode_offset_code};
         end
         lfc_pkg::ADDR_POWER_MONITOR: begin
            rd_data = power_meas;
         end
         lfc_pkg::ADDR_LOOP_VOLTAGE: begin
            rd_data = loop_voltage_meas;
         end
         lfc_pkg::ADDR_LOOP_CURRENT: begin
            rd_data = loop_current_meas;
         end
         default: begin
            rd_data = lfc_pkg::READ_UNMAPPED;
         end
      endcase
   end

endmodule

// *** sim/lfc_top_checker.sv ***
// lfc_top_checker: port-level assertions for the linefeed control block.
// assumes: single clk domain, nrst asynchronous active low; bound to lfc_top.
`timescale 1ns/100ps
module lfc_top_checker (
   input wire logic clk,
   input wire logic nrst,
   input wire logic spi_cs_n,
   input wire logic spi_sdo_oe,
   input wire logic power_alarm_event,
   input wire logic [2:0] loop_current_limit_code,
   input wire logic [5:0] open_circuit_voltage_code,
   input wire logic [5:0] common_mode_offset_code,
   input wire logic [2:0] linefeed_state_field,
   input wire logic tip_drive_en,
   input wire logic ring_drive_en,
   input wire logic audio_path_en,
   input wire logic ringing_gen_en,
   input wire logic reverse_polarity,
   input wire logic power_alarm_irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   // ---------------------------------------------------------------
   // state decode
   // ---------------------------------------------------------------
   property p_open;
      linefeed_state_field == 3'h0 |=> !tip_drive_en && !ring_drive_en && !audio_path_en;
   endproperty
   a_open: assert property (p_open) else $error("open state still drives");
   property p_active;
      linefeed_state_field inside {3'h1, 3'h5} |=> tip_drive_en && ring_drive_en && !audio_path_en;
   endproperty
   a_active: assert property (p_active) else $error("active decode wrong");
   property p_oht;
      linefeed_state_field inside {3'h2, 3'h6} |=> tip_drive_en && ring_drive_en && audio_path_en;
   endproperty
   a_oht: assert property (p_oht) else $error("on-hook tx decode wrong");
   property p_tip_open;
      linefeed_state_field == 3'h3 |=> !tip_drive_en && ring_drive_en;
   endproperty
   a_tip_open: assert property (p_tip_open) else $error("tip open decode wrong");
   property p_ring_open;
      linefeed_state_field == 3'h7 |=> tip_drive_en && !ring_drive_en;
   endproperty
   a_ring_open: assert property (p_ring_open) else $error("ring open decode wrong");
   property p_ringing;
      ringing_gen_en == ($past(linefeed_state_field) == 3'h4);
   endproperty
   a_ringing: assert property (p_ringing) else $error("ringing enable wrong");
   property p_polarity;
      reverse_polarity == ($past(linefeed_state_field) inside {3'h5, 3'h6});
   endproperty
   a_polarity: assert property (p_polarity) else $error("polarity wrong");

   // ---------------------------------------------------------------
   // host port and alarm
   // ---------------------------------------------------------------
   property p_sdo_idle;
      spi_cs_n [*6] |-> !spi_sdo_oe;
   endproperty
   a_sdo_idle: assert property (p_sdo_idle) else $error("sdo driven while idle");
   property p_feed_change;
      $changed({loop_current_limit_code, open_circuit_voltage_code, common_mode_offset_code})
         |-> !spi_cs_n;
   endproperty
   a_feed_change: assert property (p_feed_change) else $error("feed changed outside frame");
   property p_field_change;
      $changed(linefeed_state_field) |-> !spi_cs_n || $past(power_alarm_event);
   endproperty
   a_field_change: assert property (p_field_change) else $error("state changed unasked");
   property p_irq_rise;
      $rose(power_alarm_irq) |-> $past(power_alarm_event, 2) || !spi_cs_n;
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("irq without event");
endmodule

bind lfc_top lfc_top_checker u_lfc_top_checker (
   .clk(clk), .nrst(nrst), .spi_cs_n(spi_cs_n), .spi_sdo_oe(spi_sdo_oe),
   .power_alarm_event(power_alarm_event),
   .loop_current_limit_code(loop_current_limit_code),
   .open_circuit_voltage_code(open_circuit_voltage_code),
   .common_mode_offset_code(common_mode_offset_code),
   .linefeed_state_field(linefeed_state_field), .tip_drive_en(tip_drive_en),
   .ring_drive_en(ring_drive_en), .audio_path_en(audio_path_en),
   .ringing_gen_en(ringing_gen_en), .reverse_polarity(reverse_polarity),
   .power_alarm_irq(power_alarm_irq)
);

// *** sim/lfc_host_model.sv ***
// lfc_host_model: host controller driving 16-bit mode 3 serial frames.
// assumes: sclk phases of 5 clk, well above the 4 clk minimum.
`timescale 1ns/100ps
module lfc_host_model (
   input wire logic clk,
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_sdi,
   input wire logic spi_sdo_out,
   input wire logic spi_sdo_oe
);
   initial begin
      spi_sclk = 1'b1;
      spi_cs_n = 1'b1;
      spi_sdi = 1'b1;
   end

   // one frame msb first, shift on fall, device samples on rise
   task automatic xfer(input logic [15:0] f, input int nb, output logic [7:0] rd);
      rd = 8'h00;
      spi_cs_n = 1'b0;
      for (int i = 15; i > 15 - nb; i--) begin
         repeat (5) @(negedge clk);
         spi_sclk = 1'b0;
         spi_sdi = f[i];
         repeat (5) @(negedge clk);
         if (i < 8) begin
            rd = {rd[6:0], spi_sdo_oe ? spi_sdo_out : ~spi_sdo_out};
         end
         spi_sclk = 1'b1;
      end
      repeat (8) @(negedge clk);
      spi_cs_n = 1'b1;
      // released line shows no stale bit
      spi_sdi = ~spi_sdi;
      repeat (6) @(negedge clk);
   endtask
endmodule

// *** sim/lfc_top_bench.sv ***
// lfc_top_bench: register-level tests of the linefeed control block.
// assumes: lfc_host_model as serial host; inputs change at clk falling edge.
`timescale 1ns/100ps
module lfc_top_bench;
   logic clk, nrst, meas_valid, power_alarm_event;
   logic [7:0] meas_loop_voltage, meas_loop_current, meas_power, rd;
   logic spi_sclk, spi_cs_n, spi_sdi, spi_sdo_out, spi_sdo_oe;
   logic [2:0] loop_current_limit_code, linefeed_state_field;
   logic [5:0] open_circuit_voltage_code, common_mode_offset_code;
   logic tip_drive_en, ring_drive_en, audio_path_en, ringing_gen_en;
   logic reverse_polarity, power_alarm_irq;
   logic [4:0] drv;
   int fail_count = 0;
   int n_checks = 0;
   // tip, ring, audio, ringing, reverse per state code
   localparam logic [4:0] DRV [8] = '{5'h00, 5'h18, 5'h1C, 5'h08, 5'h1A, 5'h19, 5'h1D, 5'h10};
   localparam logic [6:0] FA [3] = '{7'h47, 7'h48, 7'h49};
   localparam logic [7:0] FM [3] = '{8'h07, 8'h3F, 8'h3F};

   assign drv = {tip_drive_en, ring_drive_en, audio_path_en, ringing_gen_en, reverse_polarity};

   lfc_top u_lfc_top (
      .clk(clk), .nrst(nrst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_sdi(spi_sdi), .spi_sdo_out(spi_sdo_out), .spi_sdo_oe(spi_sdo_oe),
      .meas_valid(meas_valid), .meas_loop_voltage(meas_loop_voltage),
      .meas_loop_current(meas_loop_current), .meas_power(meas_power),
      .power_alarm_event(power_alarm_event),
      .loop_current_limit_code(loop_current_limit_code),
      .open_circuit_voltage_code(open_circuit_voltage_code),
      .common_mode_offset_code(common_mode_offset_code),
      .linefeed_state_field(linefeed_state_field), .tip_drive_en(tip_drive_en),
      .ring_drive_en(ring_drive_en), .audio_path_en(audio_path_en),
      .ringing_gen_en(ringing_gen_en), .reverse_polarity(reverse_polarity),
      .power_alarm_irq(power_alarm_irq)
   );

   lfc_host_model u_lfc_host_model (
      .clk(clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
      .spi_sdo_out(spi_sdo_out), .spi_sdo_oe(spi_sdo_oe)
   );

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] r;
      u_lfc_host_model.xfer({1'b0, a, d}, 16, r);
   endtask

   task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp, input string what);
      logic [7:0] r;
      u_lfc_host_model.xfer({1'b1, a, 8'h00}, 16, r);
      check(r, exp, what);
   endtask

   task automatic pulse_alarm();
      power_alarm_event = 1'b1;
      @(negedge clk);
      power_alarm_event = 1'b0;
      repeat (3) @(negedge clk);
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      #400000;
      fail_count++;
      $display("Error at %0t: watchdog expired", $time);
      stop_test();
   end

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      nrst = 1'b0;
      meas_valid = 1'b0;
      power_alarm_event = 1'b0;
      meas_loop_voltage = 8'h00;
      meas_loop_current = 8'h00;
      meas_power = 8'h00;
      repeat (5) @(negedge clk);
      nrst = 1'b1;
      repeat (5) @(negedge clk);
      check({5'h00, linefeed_state_field}, 8'h00, "reset state");
      check({3'h0, drv}, 8'h00, "reset drive");
      rd_chk(7'h47, 8'h00, "reset limit");
      rd_chk(7'h48, 8'h20, "reset voltage");
      rd_chk(7'h49, 8'h02, "reset offset");
      $display("test reset done");
      for (int i = 0; i < 3; i++) begin
         wr(FA[i], 8'hFF);
         rd_chk(FA[i], FM[i], "feed top");
      end
      check({5'h00, loop_current_limit_code}, 8'h07, "limit pin");
      check({2'h0, open_circuit_voltage_code}, 8'h3F, "voltage pin");
      check({2'h0, common_mode_offset_code}, 8'h3F, "offset pin");
      $display("test feed done");
      for (int s = 0; s < 8; s++) begin
         wr(7'h40, 8'(s));
         check({5'h00, linefeed_state_field}, 8'(s), "state pin");
         check({3'h0, drv}, {3'h0, DRV[s]}, "decode");
         rd_chk(7'h40, 8'(s), "state read");
      end
      $display("test states done");
      u_lfc_host_model.xfer({1'b0, 7'h40, 8'h01}, 12, rd);
      check({5'h00, linefeed_state_field}, 8'h07, "aborted frame");
      wr(7'h7F, 8'hFF);
      rd_chk(7'h7F, 8'h00, "unmapped");
      $display("test refusals done");
      meas_loop_voltage = 8'hA5;
      meas_loop_current = 8'h3C;
      meas_power = 8'h5A;
      meas_valid = 1'b1;
      @(negedge clk);
      meas_valid = 1'b0;
      rd_chk(7'h4E, 8'hA5, "loop voltage");
      rd_chk(7'h4F, 8'h3C, "loop current");
      rd_chk(7'h4D, 8'h5A, "power");
      $display("test measure done");
      wr(7'h40, 8'h01);
      wr(7'h44, 8'h02);
      pulse_alarm();
      check({5'h00, linefeed_state_field}, 8'h01, "no auto open");
      check({7'h00, power_alarm_irq}, 8'h01, "irq set");
      rd_chk(7'h45, 8'h01, "alarm flag");
      wr(7'h45, 8'h01);
      check({7'h00, power_alarm_irq}, 8'h00, "irq cleared");
      wr(7'h44, 8'h03);
      pulse_alarm();
      check({5'h00, linefeed_state_field}, 8'h00, "auto open");
      check({3'h0, drv}, 8'h00, "auto open drive");
      check({7'h00, power_alarm_irq}, 8'h01, "irq again");
      $display("test alarm done");
      nrst = 1'b0;
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      repeat (5) @(negedge clk);
      check({5'h00, loop_current_limit_code}, 8'h00, "limit after reset");
      check({2'h0, open_circuit_voltage_code}, 8'h20, "voltage after reset");
      check({2'h0, common_mode_offset_code}, 8'h02, "offset after reset");
      check({7'h00, power_alarm_irq}, 8'h00, "irq after reset");
      rd_chk(7'h48, 8'h20, "voltage read after reset");
      $display("test restart done");
      stop_test();
   end
endmodule
